// ### rtl/pbsa_top.sv
// access logic of a two-stage pipelined burst static memory of 18-bit words
// assumes the bus master runs on ref_clk; output enable, burst order and
// sleep arrive from outside that domain and are filtered here

// Notes on behaviour
// - clocked inputs except enable, order, sleep
// - sleep powers down, keeping all state
// - two cycles of wake-up before access
// - processor strobe loads address, starts read
// - read data registered, then to buffer
// - advance ignored on processor strobe edge
// - read burst steps when no write, advance
// - advance high holds current burst address
// - primary select high blocks processor strobe
// - global write writes both lanes
// - write enables ignored on processor strobe edge
// - sampled write turns data drivers off
// - sampled write captures data bus
// - write burst steps on write with advance
// - lane enables write only their lanes
// - controller strobe samples write enables immediately
// - burst starts at external address, wraps
// - order select: linear or interleaved
// - later burst addresses made internally
// - only the one select pattern selects
// - controller strobe begins write or read
// - combined write indication from enables
module pbsa_top (
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire logic                        clk_en,
    input  wire logic [pbsa_pkg::ADDR_W-1:0] word_address,
    input  wire logic                        proc_addr_strobe_n,
    input  wire logic                        ctrl_addr_strobe_n,
    input  wire logic                        burst_advance_n,
    input  wire logic                        primary_select_n,
    input  wire logic                        second_select,
    input  wire logic                        third_select_n,
    input  wire logic                        all_lanes_write_n,
    input  wire logic                        lane_write_gate_n,
    input  wire logic                        lane_a_write_en_n,
    input  wire logic                        lane_b_write_en_n,
    input  wire logic                        out_enable_n,
    input  wire logic                        burst_order_select,
    input  wire logic                        sleep_request,
    input  wire logic [pbsa_pkg::BYTE_W-1:0] lane_a_data_in,
    input  wire logic                        lane_a_parity_in,
    input  wire logic [pbsa_pkg::BYTE_W-1:0] lane_b_data_in,
    input  wire logic                        lane_b_parity_in,
    output logic      [pbsa_pkg::BYTE_W-1:0] lane_a_data_out,
    output logic                             lane_a_parity_out,
    output logic      [pbsa_pkg::BYTE_W-1:0] lane_b_data_out,
    output logic                             lane_b_parity_out,
    output logic                             data_oe,
    output logic                             sleeping,
    output logic                             ready
);
    import pbsa_pkg::*;

    logic [DATA_W-1:0]     mem [0:DEPTH-1];

    logic [SYNC_DEPTH-1:0] oe_sync_r;
    logic [SYNC_DEPTH-1:0] sleep_sync_r;
    logic [SYNC_DEPTH-1:0] order_sync_r;
    logic                  oe_n_f_r;
    logic                  sleep_f_r;
    logic                  order_f_r;

    pbsa_pwr_type          pwr_r;
    pbsa_pwr_type          pwr_nxt;
    logic [WAKE_CNT_W-1:0] wake_cnt_r;
    pbsa_bst_type          bst_r;
    pbsa_bst_type          bst_nxt;

    logic [ADDR_W-1:BURST_LO_W] addr_hi_r;
    logic [BURST_LO_W-1:0]  cur_lo;
    logic [BURST_LO_W-1:0]  nxt_lo;
    logic [ADDR_W-1:0]      cur_addr;

    logic                  sel_ok;
    logic                  active;
    logic                  proc_start;
    logic                  ctrl_start;
    logic                  desel_now;
    logic                  wr_ind_n;
    logic                  load_now;
    logic                  step_now;
    logic                  wr_now;
    logic [ADDR_W-1:0]     wr_addr_now;
    logic [LANES-1:0]      wr_lanes_now;

    logic                  wr_pend_r;
    logic [ADDR_W-1:0]     wr_addr_r;
    logic [LANES-1:0]      wr_lanes_r;
    logic [DATA_W-1:0]     din_r;
    logic [DATA_W-1:0]     bus_in;
    logic [DATA_W-1:0]     mem_word;
    logic [DATA_W-1:0]     dout_r;
    logic                  dvalid_r;
    logic [DATA_W-1:0]     q_r;
    logic                  oe_r;

    // lanes written by the enables; empty mask means a read
    function automatic logic [LANES-1:0] lane_mask(
        input logic gw_n,
        input logic gate_n,
        input logic a_n,
        input logic b_n
    );
        logic [LANES-1:0] m;
        m = NO_LANES;
        if (!gw_n) begin
            m = ALL_LANES;
        end else if (!gate_n) begin
            m[LANE_A_BIT] = !a_n;
            m[LANE_B_BIT] = !b_n;
        end
        return m;
    endfunction

    // keep lanes of old, replace enabled lanes with new
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [LANES-1:0]  m
    );
        logic [DATA_W-1:0] r;
        r = old_w;
        if (m[LANE_A_BIT]) begin
            r[LANE_A_LSB +: LANE_W] = new_w[LANE_A_LSB +: LANE_W];
        end
        if (m[LANE_B_BIT]) begin
            r[LANE_B_LSB +: LANE_W] = new_w[LANE_B_LSB +: LANE_W];
        end
        return r;
    endfunction

    // three-stage filter: a change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            oe_sync_r    <= {SYNC_DEPTH{OE_N_RST}};
            sleep_sync_r <= {SYNC_DEPTH{SLEEP_RST}};
            order_sync_r <= {SYNC_DEPTH{ORDER_RST}};
            oe_n_f_r     <= OE_N_RST;
            sleep_f_r    <= SLEEP_RST;
            order_f_r    <= ORDER_RST;
        end else if (clk_en) begin
            oe_sync_r    <= {oe_sync_r[1:0], out_enable_n};
            sleep_sync_r <= {sleep_sync_r[1:0], sleep_request};
            order_sync_r <= {order_sync_r[1:0], burst_order_select};
            if (oe_sync_r[1] == oe_sync_r[2]) begin
                oe_n_f_r <= oe_sync_r[2];
            end
            if (sleep_sync_r[1] == sleep_sync_r[2]) begin
                sleep_f_r <= sleep_sync_r[2];
            end
            // order is expected static; filtering only guards glitches
            if (order_sync_r[1] == order_sync_r[2]) begin
                order_f_r <= order_sync_r[2];
            end
        end
    end

    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            PWR_ON: begin
                if (sleep_f_r) pwr_nxt = PWR_SLEEP;
            end
            PWR_SLEEP: begin
                if (!sleep_f_r) pwr_nxt = PWR_WAKE;
            end
            PWR_WAKE: begin
                if (sleep_f_r) begin
                    pwr_nxt = PWR_SLEEP;
                end else if (wake_cnt_r == WAKE_LAST) begin
                    pwr_nxt = PWR_ON;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pwr_r      <= PWR_ON;
            wake_cnt_r <= '0;
            sleeping   <= 1'b0;
            ready      <= 1'b1;
        end else if (clk_en) begin
            pwr_r    <= pwr_nxt;
            sleeping <= (pwr_nxt == PWR_SLEEP);
            ready    <= (pwr_nxt == PWR_ON);
            if (pwr_r == PWR_WAKE) begin
                wake_cnt_r <= WAKE_CNT_W'(wake_cnt_r + 2'h1);
            end else begin
                wake_cnt_r <= '0;
            end
        end
    end

    // strobes are only looked at while fully awake; asleep nothing moves
    assign active     = (pwr_r == PWR_ON) && !sleep_f_r;
    assign sel_ok     = !primary_select_n && second_select
                        && !third_select_n;
    // primary select high masks the processor strobe entirely
    assign proc_start = active && !proc_addr_strobe_n
                        && !primary_select_n;
    assign ctrl_start = active && !proc_start
                        && !ctrl_addr_strobe_n;
    assign desel_now  = (proc_start || ctrl_start) && !sel_ok;
    assign load_now   = (proc_start || ctrl_start) && sel_ok;

    assign wr_lanes_now = lane_mask(all_lanes_write_n, lane_write_gate_n,
                                    lane_a_write_en_n, lane_b_write_en_n);
    assign wr_ind_n     = (wr_lanes_now == NO_LANES);

    assign cur_addr = {addr_hi_r, cur_lo};
    assign bus_in   = {lane_b_parity_in, lane_b_data_in,
                       lane_a_parity_in, lane_a_data_in};

    always_comb begin
        bst_nxt     = bst_r;
        step_now    = 1'b0;
        wr_now      = 1'b0;
        wr_addr_now = cur_addr;
        if (proc_start) begin
            // write enables and advance are not looked at on this edge
            bst_nxt = sel_ok ? BST_READ : BST_IDLE;
        end else if (ctrl_start) begin
            if (!sel_ok) begin
                bst_nxt = BST_IDLE;
            end else if (!wr_ind_n) begin
                bst_nxt     = BST_WRITE;
                wr_now      = 1'b1;
                wr_addr_now = word_address;
            end else begin
                bst_nxt = BST_READ;
            end
        end else if (active && ctrl_addr_strobe_n
                     && bst_r != BST_IDLE) begin
            if (!wr_ind_n) begin
                bst_nxt  = BST_WRITE;
                wr_now   = 1'b1;
                step_now = !burst_advance_n;
                wr_addr_now = step_now ? {addr_hi_r, nxt_lo}
                                       : cur_addr;
            end else begin
                bst_nxt  = BST_READ;
                step_now = !burst_advance_n;
            end
        end
    end

    pbsa_burst_ctr u_ctr (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .clk_en     (clk_en),
        .load       (load_now),
        .start_bits (word_address[BURST_LO_W-1:0]),
        .step       (step_now),
        .order_il   (order_f_r),
        .cur_bits   (cur_lo),
        .nxt_bits   (nxt_lo)
    );

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bst_r     <= BST_IDLE;
            addr_hi_r <= ADDR_RST[ADDR_W-1:BURST_LO_W];
        end else if (clk_en) begin
            bst_r <= bst_nxt;
            if (load_now) begin
                addr_hi_r <= word_address[ADDR_W-1:BURST_LO_W];
            end
        end
    end

    // write is posted one edge later from the input register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= ADDR_RST;
            wr_lanes_r <= NO_LANES;
            din_r      <= DATA_RST;
        end else if (clk_en) begin
            wr_pend_r <= wr_now;
            if (wr_now) begin
                din_r      <= bus_in;
                wr_addr_r  <= wr_addr_now;
                wr_lanes_r <= wr_lanes_now;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en && wr_pend_r) begin
            mem[wr_addr_r] <= merge(mem[wr_addr_r], din_r, wr_lanes_r);
        end
    end

    // forward a posted write so a read right behind it sees the new data
    always_comb begin
        mem_word = mem[cur_addr];
        if (wr_pend_r && wr_addr_r == cur_addr) begin
            mem_word = merge(mem_word, din_r, wr_lanes_r);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dout_r   <= DATA_RST;
            dvalid_r <= 1'b0;
            q_r      <= DATA_RST;
        end else if (clk_en && active) begin
            dout_r   <= mem_word;
            dvalid_r <= (bst_r == BST_READ);
            q_r      <= dout_r;
        end
    end

    // output enable passes the pin filter, so it acts a few edges late
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            oe_r <= 1'b0;
        end else if (clk_en) begin
            oe_r <= dvalid_r && !oe_n_f_r && active && !desel_now
                    && bst_nxt == BST_READ
                    && (wr_ind_n || proc_start);
        end
    end

    assign lane_a_data_out   = q_r[LANE_A_LSB +: BYTE_W];
    assign lane_a_parity_out = q_r[LANE_A_LSB + BYTE_W];
    assign lane_b_data_out   = q_r[LANE_B_LSB +: BYTE_W];
    assign lane_b_parity_out = q_r[LANE_B_LSB + BYTE_W];
    assign data_oe           = oe_r;

endmodule

// ### pkg/pbsa_pkg.sv
// constants and types for the pipelined burst static memory access logic
// assumes one 40 MHz clock and a bus master on that same clock
package pbsa_pkg;

    localparam int ADDR_W      = 18;
    localparam int DEPTH       = 262144;
    localparam int DATA_W      = 18;
    localparam int BYTE_W      = 8;
    localparam int LANE_W      = 9;
    localparam int LANES       = 2;
    localparam int LANE_A_LSB  = 0;
    localparam int LANE_B_LSB  = 9;
    localparam int LANE_A_BIT  = 0;
    localparam int LANE_B_BIT  = 1;
    localparam int BURST_LO_W  = 2;
    localparam int SYNC_DEPTH  = 3;

    // clock and wake-up timing
    localparam int CLK_FREQ_MHZ     = 40;
    localparam int WAKE_CYCLES_DOC  = 2;
    localparam int WAKE_CNT_W       = 2;
    localparam logic [WAKE_CNT_W-1:0] WAKE_LAST =
        WAKE_CNT_W'(WAKE_CYCLES_DOC - 1);

    // reset values of the filtered asynchronous pins
    localparam logic OE_N_RST   = 1'b1;
    localparam logic SLEEP_RST  = 1'b0;
    localparam logic ORDER_RST  = 1'b0;

    localparam logic [BURST_LO_W-1:0] BEAT_RST = 2'h0;
    localparam logic [LANES-1:0]      NO_LANES = 2'h0;
    localparam logic [LANES-1:0]      ALL_LANES = 2'h3;
    localparam logic [ADDR_W-1:0]     ADDR_RST = 18'h00000;
    localparam logic [DATA_W-1:0]     DATA_RST = 18'h00000;

    typedef enum logic [2:0] {
        PWR_ON    = 3'h1,
        PWR_SLEEP = 3'h2,
        PWR_WAKE  = 3'h4
    } pbsa_pwr_type;

    typedef enum logic [2:0] {
        BST_IDLE  = 3'h1,
        BST_READ  = 3'h2,
        BST_WRITE = 3'h4
    } pbsa_bst_type;

endpackage

// ### rtl/pbsa_burst_ctr.sv
// two-bit burst counter producing linear or interleaved low address bits
// assumes the parent loads it on every selected cycle start and steps it on advance
module pbsa_burst_ctr
    import pbsa_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    input  wire logic                  load,
    input  wire logic [BURST_LO_W-1:0] start_bits,
    input  wire logic                  step,
    input  wire logic                  order_il,
    output logic      [BURST_LO_W-1:0] cur_bits,
    output logic      [BURST_LO_W-1:0] nxt_bits
);
    import pbsa_pkg::*;

    logic [BURST_LO_W-1:0] start_r;
    logic [BURST_LO_W-1:0] beat_r;
    logic [BURST_LO_W-1:0] beat_nxt;

    function automatic logic [BURST_LO_W-1:0] seq_bits(
        input logic                  il,
        input logic [BURST_LO_W-1:0] s,
        input logic [BURST_LO_W-1:0] b
    );
        logic [BURST_LO_W-1:0] r;
        r = il ? (s ^ b) : BURST_LO_W'(s + b);
        return r;
    endfunction

    // two-bit beat count wraps to zero after the fourth beat
    assign beat_nxt = BURST_LO_W'(beat_r + 2'h1);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            start_r <= BEAT_RST;
            beat_r  <= BEAT_RST;
        end else if (clk_en) begin
            if (load) begin
                start_r <= start_bits;
                beat_r  <= BEAT_RST;
            end else if (step) begin
                beat_r  <= beat_nxt;
            end
        end
    end

    assign cur_bits = seq_bits(order_il, start_r, beat_r);
    assign nxt_bits = seq_bits(order_il, start_r, beat_nxt);

endmodule

// ### sim/pbsa_top_sva.sv
// assertions on the ports of the burst memory access logic
// assumes one clock domain and the 3-4 edge filters on oe, sleep and order
module pbsa_top_sva
    import pbsa_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              resetn,
    input wire logic              clk_en,
    input wire logic              proc_addr_strobe_n,
    input wire logic              ctrl_addr_strobe_n,
    input wire logic              primary_select_n,
    input wire logic              second_select,
    input wire logic              third_select_n,
    input wire logic              all_lanes_write_n,
    input wire logic              lane_write_gate_n,
    input wire logic              lane_a_write_en_n,
    input wire logic              lane_b_write_en_n,
    input wire logic              out_enable_n,
    input wire logic              sleep_request,
    input wire logic [BYTE_W-1:0] lane_a_data_out,
    input wire logic              lane_a_parity_out,
    input wire logic [BYTE_W-1:0] lane_b_data_out,
    input wire logic              lane_b_parity_out,
    input wire logic              data_oe,
    input wire logic              sleeping,
    input wire logic              ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       sel_ok, wr_ind, rd_start, quiet;
    logic [2:0] oe_lo_r, oe_hi_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    assign sel_ok = !primary_select_n && second_select && !third_select_n;
    assign wr_ind = !all_lanes_write_n || (!lane_write_gate_n &&
                    !(lane_a_write_en_n && lane_b_write_en_n));
    assign rd_start = clk_en && ready && !proc_addr_strobe_n && sel_ok &&
                      !sleep_request && oe_lo_r == 3'h7;
    assign quiet = clk_en && ready && proc_addr_strobe_n &&
                   ctrl_addr_strobe_n && !wr_ind && !sleep_request;

    // saturating run lengths stand in for the unseen filter outputs
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            oe_lo_r <= 3'h0;
            oe_hi_r <= 3'h0;
        end else begin
            oe_lo_r <= out_enable_n ? 3'h0 : oe_lo_r + (oe_lo_r != 3'h7);
            oe_hi_r <= !out_enable_n ? 3'h0 : oe_hi_r + (oe_hi_r != 3'h7);
        end
    end

    AST_READ_OE: assert property (rd_start ##1 quiet [*2] |=> data_oe)
        else $error("read data not driven two edges after start");
    AST_WRITE_OFF: assert property (clk_en && ready && proc_addr_strobe_n &&
        wr_ind |=> !data_oe) else $error("drivers on after write edge");
    AST_DESEL_OFF: assert property (clk_en && ready && !sel_ok &&
        ((!proc_addr_strobe_n && !primary_select_n) ||
         (proc_addr_strobe_n && !ctrl_addr_strobe_n)) |=> !data_oe)
        else $error("drivers on after deselect");
    AST_SLEEP_OFF: assert property (sleeping ##1 sleeping |-> !data_oe)
        else $error("drivers on while asleep");
    AST_SLEEP_HOLD: assert property (sleeping [*2] ##1 sleeping |->
        $stable({lane_b_parity_out, lane_b_data_out,
                 lane_a_parity_out, lane_a_data_out}))
        else $error("outputs changed while asleep");
    AST_NOT_READY: assert property (sleeping |-> !ready)
        else $error("ready while asleep");
    AST_WAKE_DELAY: assert property ($fell(sleeping) |-> !ready ##[1:3] ready)
        else $error("wake-up delay wrong");
    AST_OE_HIGH_OFF: assert property (oe_hi_r == 3'h7 |-> !data_oe)
        else $error("drivers on with output enable high");

    COV_READ: cover property (rd_start);
    COV_WRITE: cover property (proc_addr_strobe_n && !ctrl_addr_strobe_n &&
                               wr_ind && sel_ok);
    COV_SLEEP: cover property ($rose(sleeping));
endmodule

// ### sim/pbsa_master_model.sv
// far-side bus master: data lines and output enable of the memory bus
// assumes the bench says when a write beat is on the bus
module pbsa_master_model
    import pbsa_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              wr_on,
    input  wire logic [DATA_W-1:0] wr_word,
    output logic      [BYTE_W-1:0] lane_a_data_in,
    output logic                   lane_a_parity_in,
    output logic      [BYTE_W-1:0] lane_b_data_in,
    output logic                   lane_b_parity_in,
    output logic                   out_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] idle_r = 18'h15555;
    logic [DATA_W-1:0] bus;

    // a released bus flips every cycle, so stale data never passes as good
    always_ff @(posedge ref_clk) begin
        idle_r <= ~idle_r;
    end
    assign bus = wr_on ? wr_word : idle_r;
    assign {lane_b_parity_in, lane_b_data_in} = bus[DATA_W-1:LANE_B_LSB];
    assign {lane_a_parity_in, lane_a_data_in} = bus[LANE_W-1:0];
    assign out_enable_n = wr_on;
endmodule

// ### sim/pbsa_top_test.sv
// self-checking bench of the burst memory access logic
// assumes the master model on the data pins and the checker bound below
module pbsa_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pbsa_pkg::*;

    typedef struct {
        int                cyc;
        logic [DATA_W-1:0] word;
    } pbsa_note_type;

    logic              ref_clk = 1'b0;
    logic              resetn, clk_en, sleep_request, burst_order_select;
    logic              proc_addr_strobe_n, ctrl_addr_strobe_n;
    logic              burst_advance_n, primary_select_n, second_select;
    logic              third_select_n, all_lanes_write_n, lane_write_gate_n;
    logic              lane_a_write_en_n, lane_b_write_en_n, out_enable_n;
    logic              lane_a_parity_in, lane_b_parity_in, wr_on;
    logic              lane_a_parity_out, lane_b_parity_out;
    logic              data_oe, sleeping, ready;
    logic [BYTE_W-1:0] lane_a_data_in, lane_b_data_in;
    logic [BYTE_W-1:0] lane_a_data_out, lane_b_data_out;
    logic [ADDR_W-1:0] word_address, base;
    logic [DATA_W-1:0] wr_word;
    logic [DATA_W-1:0] mem [int];
    pbsa_note_type     notes [$];
    logic [31:0]       lfsr = 32'h1EEE0D27;
    int                cyc, mismatches, num_checks;

    pbsa_top dut (.*);
    pbsa_master_model u_master (.*);

    always #12.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic [ADDR_W-1:0] beat_addr(logic [ADDR_W-1:0] a,
                                                    logic [1:0] b);
        logic [1:0] lo;
        lo = burst_order_select ? (a[1:0] ^ b) : (a[1:0] + b);
        return {a[ADDR_W-1:2], lo};
    endfunction

    task automatic check(string what, logic [DATA_W:0] seen,
                         logic [DATA_W:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(int n = 1);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic idle(int n, logic oe_off = 1'b0);
        proc_addr_strobe_n = 1'b1;
        ctrl_addr_strobe_n = 1'b1;
        burst_advance_n = 1'b1;
        primary_select_n = 1'b0;
        all_lanes_write_n = 1'b1;
        lane_write_gate_n = 1'b1;
        lane_a_write_en_n = 1'b1;
        lane_b_write_en_n = 1'b1;
        wr_on = oe_off;
        tick(n);
    endtask

    // four full-word beats, then a lane-b beat on the wrapped first address
    task automatic wr_burst(logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] d;
        logic [ADDR_W-1:0] wa;
        for (int b = 0; b < 5; b++) begin
            d = DATA_W'(next_rand());
            wa = beat_addr(a, 2'(b));
            ctrl_addr_strobe_n = (b != 0);
            proc_addr_strobe_n = 1'b1;
            burst_advance_n = (b == 0);
            word_address = a;
            all_lanes_write_n = (b == 4);
            lane_write_gate_n = (b != 4);
            lane_a_write_en_n = (b == 4);
            lane_b_write_en_n = 1'b0;
            wr_on = 1'b1;
            wr_word = d;
            if (b == 4)
                mem[wa][DATA_W-1:LANE_B_LSB] = d[DATA_W-1:LANE_B_LSB];
            else
                mem[wa] = d;
            tick();
        end
        idle(8);
    endtask

    task automatic rd_burst(logic [ADDR_W-1:0] a);
        logic [1:0] bt;
        bt = 2'h0;
        for (int e = 0; e < 6; e++) begin
            proc_addr_strobe_n = !(e == 0 || e == 5);
            primary_select_n = (e == 5);
            all_lanes_write_n = (e != 0);
            burst_advance_n = (e == 2 || e == 5);
            word_address = (e == 5) ? ~a : a;
            if (e != 0 && !burst_advance_n)
                bt++;
            notes.push_back('{cyc + 3, mem[beat_addr(a, bt)]});
            tick();
        end
        idle(2);
        idle(8, 1'b1);
        check("oe pin high", {18'h00000, data_oe}, 19'h00000);
        idle(6);
        ctrl_addr_strobe_n = 1'b0;
        second_select = 1'b0;
        tick();
        second_select = 1'b1;
        idle(1);
        check("oe desel", {18'h00000, data_oe}, 19'h00000);
        idle(5);
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 1500) begin
            mismatches++;
            end_sim();
        end
        #1;
        if (notes.size() != 0 && notes[0].cyc == cyc) begin
            check("read word", {data_oe, lane_b_parity_out, lane_b_data_out,
                  lane_a_parity_out, lane_a_data_out},
                  {1'b1, notes[0].word});
            void'(notes.pop_front());
        end
    end

    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        sleep_request = 1'b0;
        burst_order_select = 1'b0;
        second_select = 1'b1;
        third_select_n = 1'b0;
        word_address = 18'h00000;
        wr_word = 18'h00000;
        idle(10);
        resetn = 1'b1;
        for (int p = 0; p < 2; p++) begin
            burst_order_select = p[0];
            idle(8);
            base = ADDR_W'(next_rand());
            wr_burst(base);
            rd_burst(base);
            $display("burst test in order %0d done", p);
        end
        sleep_request = 1'b1;
        for (int i = 0; i < 20 && sleeping !== 1'b1; i++)
            tick();
        check("ready asleep", {17'h00000, sleeping, ready}, 19'h00002);
        tick(4);
        sleep_request = 1'b0;
        for (int i = 0; i < 20 && ready !== 1'b1; i++)
            tick();
        check("ready awake", {17'h00000, sleeping, ready}, 19'h00001);
        rd_burst(base);
        $display("sleep test done");
        end_sim();
    end
endmodule

bind pbsa_top pbsa_top_sva u_sva (.*);
